// *** src/tcc_pkg.sv ***
package tcc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register offsets
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_RUN = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_PRESCALE = 8'h34;
  // field positions
  localparam int BIT_MODULE_ENABLE = 7;
  localparam int BIT_PRESCALER_RUN = 2;
  localparam int BIT_COUNTER_RUN = 0;
  localparam int BIT_DOUBLE_BUFFER = 7;
  localparam int BIT_SYNC_START = 5;
  localparam int BIT_IDLE_OPERATE = 3;
  // reset values
  localparam logic RST_ENABLE = 1'b0;
  localparam logic [DATA_W-1:0] RST_RUN = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_CONTROL = 32'h0000_0000;
  localparam int CNT_W = 16;
  localparam int PRE_W = 8;
  localparam logic [PRE_W-1:0] RST_PRESCALE = 8'h00;
endpackage : tcc_pkg

// *** src/tcc_channel.sv ***
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module tcc_channel #(
  parameter int CNT_WIDTH = tcc_pkg::CNT_W,
  parameter int PRE_WIDTH = tcc_pkg::PRE_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [tcc_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [tcc_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [tcc_pkg::DATA_W-1:0] bus_rdata,
  input wire logic master_run,
  input wire logic sys_idle,
  output logic [CNT_WIDTH-1:0] count_value,
  output logic prescale_tick,
  output logic counter_running,
  output logic double_buffer_enable,
  output logic module_enable
);
  import tcc_pkg::*;

  initial begin
    if (CNT_WIDTH != 16 || PRE_WIDTH < 1 || PRE_WIDTH > 16) begin
      $error("tcc_channel: unsupported width");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic enable_reg;
  logic prescaler_run_reg;
  logic counter_run_reg;
  logic double_buffer_reg;
  logic sync_start_reg;
  logic idle_operate_reg;
  logic [PRE_WIDTH-1:0] prescale_div_reg;
  logic [PRE_WIDTH-1:0] prescale_cnt_reg;
  logic [CNT_WIDTH-1:0] count_reg;
  logic tick_reg;

  // gated clock enable for the run, control, prescale, prescaler and count registers; read data and outputs use clk_en
  logic chan_ce;
  logic wr_ok;
  logic run_gate;
  logic stall_idle;
  logic tick_now;
  assign chan_ce = clk_en && enable_reg;
  assign wr_ok = bus_wr && chan_ce;
  // sync mode: counting also waits for the group master run
  assign run_gate = counter_run_reg && (!sync_start_reg || master_run);
  assign stall_idle = sys_idle && !idle_operate_reg;
  assign tick_now = prescaler_run_reg && !stall_idle && (prescale_cnt_reg == prescale_div_reg);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      enable_reg <= RST_ENABLE;
    end else if (clk_en && bus_wr && bus_addr == OFS_ENABLE) begin
      enable_reg <= bus_wdata[BIT_MODULE_ENABLE];
    end
  end

  // held while disabled, so settings survive
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prescaler_run_reg <= RST_RUN[BIT_PRESCALER_RUN];
      counter_run_reg <= RST_RUN[BIT_COUNTER_RUN];
    end else if (wr_ok && bus_addr == OFS_RUN) begin
      prescaler_run_reg <= bus_wdata[BIT_PRESCALER_RUN];
      counter_run_reg <= bus_wdata[BIT_COUNTER_RUN];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      double_buffer_reg <= RST_CONTROL[BIT_DOUBLE_BUFFER];
      sync_start_reg <= RST_CONTROL[BIT_SYNC_START];
      idle_operate_reg <= RST_CONTROL[BIT_IDLE_OPERATE];
    end else if (wr_ok && bus_addr == OFS_CONTROL) begin
      double_buffer_reg <= bus_wdata[BIT_DOUBLE_BUFFER];
      sync_start_reg <= bus_wdata[BIT_SYNC_START];
      idle_operate_reg <= bus_wdata[BIT_IDLE_OPERATE];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prescale_div_reg <= RST_PRESCALE;
    end else if (wr_ok && bus_addr == OFS_PRESCALE) begin
      prescale_div_reg <= bus_wdata[PRE_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler: divides by prescale_div_reg+1
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prescale_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (chan_ce) begin
      if (!prescaler_run_reg) begin
        prescale_cnt_reg <= '0;
        tick_reg <= 1'b0;
      end else if (stall_idle) begin
        tick_reg <= 1'b0;
      end else if (tick_now) begin
        prescale_cnt_reg <= '0;
        tick_reg <= 1'b1;
      end else begin
        prescale_cnt_reg <= prescale_cnt_reg + 1'b1;
        tick_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
    end else if (chan_ce) begin
      if (!counter_run_reg) begin
        count_reg <= '0;
      end else if (run_gate && tick_reg && !stall_idle) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data one cycle after the strobe; zero otherwise
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= '0;
    end else if (clk_en) begin
      bus_rdata <= '0;
      if (bus_rd) begin
        if (bus_addr == OFS_ENABLE) begin
          bus_rdata[BIT_MODULE_ENABLE] <= enable_reg;
        end else if (enable_reg) begin
          unique case (bus_addr)
            OFS_RUN: begin
              bus_rdata[BIT_PRESCALER_RUN] <= prescaler_run_reg;
              bus_rdata[BIT_COUNTER_RUN] <= counter_run_reg;
            end
            OFS_CONTROL: begin
              bus_rdata[BIT_DOUBLE_BUFFER] <= double_buffer_reg;
              bus_rdata[BIT_SYNC_START] <= sync_start_reg;
              bus_rdata[BIT_IDLE_OPERATE] <= idle_operate_reg;
            end
            OFS_STATUS: begin
              bus_rdata[CNT_WIDTH-1:0] <= count_reg;
              bus_rdata[CNT_WIDTH] <= run_gate;
            end
            OFS_PRESCALE: begin
              bus_rdata[PRE_WIDTH-1:0] <= prescale_div_reg;
            end
            default: begin
              bus_rdata <= '0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_value <= '0;
      prescale_tick <= 1'b0;
      counter_running <= 1'b0;
      double_buffer_enable <= 1'b0;
      module_enable <= 1'b0;
    end else if (clk_en) begin
      count_value <= count_reg;
      prescale_tick <= tick_reg;
      counter_running <= run_gate;
      double_buffer_enable <= double_buffer_reg;
      module_enable <= enable_reg;
    end
  end
endmodule : tcc_channel

// *** tb/tcc_checker.sv ***
`timescale 1ns/1ps
module tcc_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic [15:0] count_value,
  input wire logic double_buffer_enable,
  input wire logic module_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  rd_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("rdata not idle");
  en_read_a: assert property ($past(bus_rd) && $past(bus_addr) == 8'h00
    |-> (bus_rdata & 32'hFFFF_FF7F) == 32'h0) else $error("enable read");
  dis_read_a: assert property ($past(bus_rd) && $past(bus_addr) != 8'h00
    && !module_enable |-> bus_rdata == 32'h0) else $error("disabled read");
  en_out_a: assert property ($past(bus_wr) && $past(bus_addr) == 8'h00
    |=> module_enable == $past(bus_wdata[7], 2)) else $error("enable out");
  dbuf_out_a: assert property ($past(bus_wr) && $past(bus_addr) == 8'h08
    && module_enable |=> double_buffer_enable == $past(bus_wdata[7], 2)) else $error("dbuf");
  count_step_a: assert property ($changed(count_value) && count_value != 16'h0
    |-> count_value == $past(count_value) + 16'h1) else $error("count step");
  run_clear_a: assert property ($past(bus_wr) && $past(bus_addr) == 8'h04
    && !$past(bus_wdata[0]) && module_enable |-> ##2 count_value == 16'h0) else $error("clear");
  dis_freeze_a: assert property (!module_enable [*3] |-> $stable(count_value))
    else $error("count not frozen");
endmodule : tcc_checker

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import tcc_pkg::*;
  logic clk_sys = 0, nrst = 0, bus_wr = 0, bus_rd = 0, master_run = 0, sys_idle = 0;
  logic clk_en = 1;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0, bus_rdata;
  logic [15:0] count_value, c;
  logic prescale_tick, counter_running, double_buffer_enable, module_enable;
  int errors = 0, tests_run = 0;
  tcc_channel dut_u (.clk_sys, .nrst, .clk_en, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .master_run, .sys_idle, .count_value, .prescale_tick, .counter_running,
    .double_buffer_enable, .module_enable);
  initial forever #2 clk_sys = ~clk_sys;
  task automatic final_report();
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic chk(logic [31:0] g, logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e);
    @(posedge clk_sys);
    bus_wr <= w;
    bus_rd <= !w;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    #1 if (!w) chk(bus_rdata, e);
  endtask : acc
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    acc(0, 8'h04, 32'h0, 32'h0);
    acc(1, 8'h04, 32'h5, 32'h0);
    acc(1, 8'h00, 32'hFFFF_FFFF, 32'h0);
    acc(0, 8'h00, 32'h0, 32'h80);
    acc(0, 8'h04, 32'h0, 32'h0);
    acc(1, 8'h08, 32'hFFFF_FFFF, 32'h0);
    acc(0, 8'h08, 32'h0, 32'hA8);
    chk(double_buffer_enable, 32'h1);
    $display("test regs done");
    acc(1, 8'h04, 32'hFFFF_FFFF, 32'h0);
    acc(0, 8'h04, 32'h0, 32'h5);
    cyc(3);
    chk(counter_running, 32'h0);
    chk(count_value, 32'h0);
    master_run <= 1'b1;
    cyc(3);
    chk(counter_running, 32'h1);
    c = count_value;
    cyc(1);
    chk(count_value, c + 16'h1);
    $display("test sync done");
    acc(1, 8'h00, 32'h0, 32'h0);
    cyc(2);
    c = count_value;
    cyc(4);
    chk(count_value, c);
    acc(1, 8'h00, 32'h80, 32'h0);
    acc(0, 8'h08, 32'h0, 32'hA8);
    acc(1, 8'h04, 32'h1, 32'h0);
    cyc(3);
    chk(prescale_tick, 32'h0);
    c = count_value;
    cyc(2);
    chk(count_value, c);
    acc(1, 8'h04, 32'h0, 32'h0);
    cyc(3);
    chk(count_value, 32'h0);
    $display("test run done");
    acc(1, 8'h08, 32'h0, 32'h0);
    sys_idle <= 1'b1;
    acc(1, 8'h04, 32'h5, 32'h0);
    cyc(4);
    chk(count_value, 32'h0);
    sys_idle <= 1'b0;
    cyc(4);
    chk(32'(count_value != 16'h0), 32'h1);
    c = count_value;
    clk_en <= 1'b0;
    cyc(4);
    chk(count_value, c);
    clk_en <= 1'b1;
    cyc(3);
    chk(32'(count_value != c), 32'h1);
    $display("test idle done");
    final_report();
  end
endmodule : testbench
bind tcc_channel tcc_checker chk_u (.clk_sys, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
  .bus_rdata, .count_value, .double_buffer_enable, .module_enable);
